// File: pssr_top.sv
// Functional notes
// - Status bit 15 (100BASE-T4 ability) always reads zero.
// - Status bits 14 to 11 read one, reporting the four supported modes.
// - Status bits 10 and 9 (100BASE-T2 abilities) always read zero.
// - Status bit 5 shows auto-negotiation complete and resets to zero.
// - Status bit 4 latches high on a remote fault and resets to zero.
// - Status bit 3 always reads one, showing auto-negotiation ability.
// - Status bit 2 shows link, latches low on any loss, resets to zero.
// - Status bit 1 latches high on jabber and resets to zero.
// - Status bit 0 always reads one for extended register support.
// - The status register is at index 1, 16 bits, read-only, bits 8:6 reserved.
// - The identifier high register at index 2 holds identifier bits 3 to 18, writable.
// - The identifier low register at index 3 holds identifier bits 19 to 24 in 15:10.
// - Bits 9:4 of the identifier low register hold a writable model number.
// - Bits 3:0 of the identifier low register hold a writable revision.
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module pssr_top
    import pssr_pkg::*;
(
    input  wire logic [PSSR_ADDR_W-1:0]    i_addr,
    input  wire logic [PSSR_DATA_W-1:0]    i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [PSSR_DATA_W-1:0]    o_rdata,
    input  wire logic [PSSR_NUM_PORTS-1:0] i_an_done,
    input  wire logic [PSSR_NUM_PORTS-1:0] i_rfault,
    input  wire logic [PSSR_NUM_PORTS-1:0] i_link_up,
    input  wire logic [PSSR_NUM_PORTS-1:0] i_jabber,
    output logic                           o_irq,
    input  wire logic                      i_core_clk,
    input  wire logic                      i_arst_n
);
    logic [PSSR_NUM_PORTS-1:0] an_s1, an_s2, rf_s1, rf_s2, lk_s1, lk_s2, jb_s1, jb_s2;
    logic [PSSR_NUM_PORTS-1:0] an_q, lk_q;
    logic [PSSR_NUM_PORTS-1:0][15:0] status, id_high, id_low;
    logic [PSSR_NUM_PORTS-1:0][PSSR_IRQ_W-1:0] irq_stat, irq_mask;
    logic [PSSR_PORT_W-1:0]    port;
    logic [3:0]                idx;

    assign port = i_addr[PSSR_PORT_LSB +: PSSR_PORT_W];
    assign idx  = i_addr[3:0];

    function automatic logic hit(input logic [3:0] want, input logic [PSSR_PORT_W-1:0] p,
                                 input int unsigned k);
        // The top address bit must be zero, so no access aliases onto a port
        hit = (want == idx) && (p == k[PSSR_PORT_W-1:0]) && !i_addr[PSSR_ADDR_W-1];
    endfunction

    // Status lines come from the PHY's own timing, so they are synchronised
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            {an_s1, an_s2, rf_s1, rf_s2} <= '0;
            {lk_s1, lk_s2, jb_s1, jb_s2} <= '0;
            {an_q, lk_q}                 <= '0;
        end else begin
            an_s1 <= i_an_done;
            an_s2 <= an_s1;
            rf_s1 <= i_rfault;
            rf_s2 <= rf_s1;
            lk_s1 <= i_link_up;
            lk_s2 <= lk_s1;
            jb_s1 <= i_jabber;
            jb_s2 <= jb_s1;
            an_q  <= an_s2;
            lk_q  <= lk_s2;
        end
    end

    for (genvar g = 0; g < PSSR_NUM_PORTS; g++) begin : g_port
        pssr_port u_port (
            .i_core_clk   (i_core_clk),
            .i_arst_n     (i_arst_n),
            .i_an_done    (an_s2[g]),
            .i_rfault     (rf_s2[g]),
            .i_link_up    (lk_s2[g]),
            .i_jabber     (jb_s2[g]),
            .i_status_rd  (i_rd && hit(PSSR_IDX_STATUS, port, g)),
            .i_id_high_wr (i_wr && hit(PSSR_IDX_ID_HIGH, port, g)),
            .i_id_low_wr  (i_wr && hit(PSSR_IDX_ID_LOW, port, g)),
            .i_wdata      (i_wdata),
            .o_status     (status[g]),
            .o_id_high    (id_high[g]),
            .o_id_low     (id_low[g])
        );

        // Sticky events; a new event beats the clear-on-read
        always_ff @(posedge i_core_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                irq_stat[g] <= '0;
            end else begin
                irq_stat[g] <= {an_s2[g] & ~an_q[g], rf_s2[g], ~lk_s2[g] & lk_q[g], jb_s2[g]}
                             | (irq_stat[g] & {PSSR_IRQ_W{~(i_rd && hit(PSSR_IDX_IRQ_STAT, port, g))}});
            end
        end

        always_ff @(posedge i_core_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                irq_mask[g] <= PSSR_RST_MASK;
            end else if (i_wr && hit(PSSR_IDX_IRQ_MASK, port, g)) begin
                irq_mask[g] <= i_wdata[PSSR_IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat & irq_mask);
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= '0;
        end else if (!i_rd || i_addr[PSSR_ADDR_W-1] || 32'(port) >= PSSR_NUM_PORTS) begin
            o_rdata <= '0;
        end else begin
            case (idx)
                PSSR_IDX_STATUS:   o_rdata <= status[port];
                PSSR_IDX_ID_HIGH:  o_rdata <= id_high[port];
                PSSR_IDX_ID_LOW:   o_rdata <= id_low[port];
                PSSR_IDX_IRQ_STAT: o_rdata <= {12'h000, irq_stat[port]};
                PSSR_IDX_IRQ_MASK: o_rdata <= {12'h000, irq_mask[port]};
                default:           o_rdata <= '0;
            endcase
        end
    end
endmodule // pssr_top

// File: pssr_pkg.sv
package pssr_pkg;
    localparam int          PSSR_NUM_PORTS    = 2;
    localparam int          PSSR_PORT_W       = 1;
    localparam int          PSSR_ADDR_W       = 6;
    localparam int          PSSR_DATA_W       = 16;
    // Address = {port, index}; index is the low 4 bits
    localparam logic [3:0]  PSSR_IDX_STATUS   = 4'h1;
    localparam logic [3:0]  PSSR_IDX_ID_HIGH  = 4'h2;
    localparam logic [3:0]  PSSR_IDX_ID_LOW   = 4'h3;
    localparam logic [3:0]  PSSR_IDX_IRQ_STAT = 4'h8;
    localparam logic [3:0]  PSSR_IDX_IRQ_MASK = 4'h9;
    localparam int          PSSR_PORT_LSB     = 4;
    // Status bit positions
    localparam int          PSSR_B_T4         = 15;
    localparam int          PSSR_B_ABIL_HI    = 14;
    localparam int          PSSR_B_ABIL_LO    = 11;
    localparam int          PSSR_B_T2_FD      = 10;
    localparam int          PSSR_B_T2_HD      = 9;
    localparam int          PSSR_B_AN_DONE    = 5;
    localparam int          PSSR_B_RFAULT     = 4;
    localparam int          PSSR_B_AN_ABLE    = 3;
    localparam int          PSSR_B_LINK       = 2;
    localparam int          PSSR_B_JABBER     = 1;
    localparam int          PSSR_B_EXT_CAP    = 0;
    // Identity fields; values arbitrary, not any real maker's codes
    localparam logic [15:0] PSSR_RST_ID_HIGH  = 16'h1234;
    localparam logic [5:0]  PSSR_RST_ORG_LOW  = 6'h15;
    localparam logic [5:0]  PSSR_RST_MODEL    = 6'h2a;
    localparam logic [3:0]  PSSR_RST_REV      = 4'h3;
    // Interrupt status bits per port: an_done, rfault, link_down, jabber
    localparam int          PSSR_IRQ_W        = 4;
    localparam logic [3:0]  PSSR_RST_MASK     = 4'h0;
endpackage

// File: pssr_port.sv
`timescale 1ns/10ps
module pssr_port
    import pssr_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_an_done,
    input  wire logic        i_rfault,
    input  wire logic        i_link_up,
    input  wire logic        i_jabber,
    input  wire logic        i_status_rd,
    input  wire logic        i_id_high_wr,
    input  wire logic        i_id_low_wr,
    input  wire logic [15:0] i_wdata,
    output logic      [15:0] o_status,
    output logic      [15:0] o_id_high,
    output logic      [15:0] o_id_low
);
    logic rfault_lat;
    logic jabber_lat;
    logic link_lat;

    // Latched-high bits: a read clears, but a live event in the same cycle wins
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rfault_lat <= 1'b0;
            jabber_lat <= 1'b0;
        end else begin
            rfault_lat <= i_rfault | (rfault_lat & ~i_status_rd);
            jabber_lat <= i_jabber | (jabber_lat & ~i_status_rd);
        end
    end

    // Latched-low link: a drop sticks until a status read made while the link is up sets it again
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            link_lat <= 1'b0;
        end else if (!i_link_up) begin
            link_lat <= 1'b0;
        end else if (i_status_rd) begin
            link_lat <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_id_high <= PSSR_RST_ID_HIGH;
        end else if (i_id_high_wr) begin
            o_id_high <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_id_low <= {PSSR_RST_ORG_LOW, PSSR_RST_MODEL, PSSR_RST_REV};
        end else if (i_id_low_wr) begin
            o_id_low <= i_wdata;
        end
    end

    always_comb begin
        o_status                                = 16'h0000;
        o_status[PSSR_B_T4]                     = 1'b0;
        o_status[PSSR_B_ABIL_HI:PSSR_B_ABIL_LO] = 4'hf;
        o_status[PSSR_B_T2_FD]                  = 1'b0;
        o_status[PSSR_B_T2_HD]                  = 1'b0;
        o_status[PSSR_B_AN_DONE]                = i_an_done;
        o_status[PSSR_B_RFAULT]                 = rfault_lat;
        o_status[PSSR_B_AN_ABLE]                = 1'b1;
        o_status[PSSR_B_LINK]                   = link_lat;
        o_status[PSSR_B_JABBER]                 = jabber_lat;
        o_status[PSSR_B_EXT_CAP]                = 1'b1;
    end
endmodule // pssr_port

// File: pssr_top_properties.sv
`timescale 1ns/10ps
module pssr_top_chk
    import pssr_pkg::*;
(
    input wire logic [PSSR_ADDR_W-1:0]    i_addr,
    input wire logic                      i_rd,
    input wire logic [PSSR_DATA_W-1:0]    o_rdata,
    input wire logic [PSSR_NUM_PORTS-1:0] i_rfault,
    input wire logic [PSSR_NUM_PORTS-1:0] i_link_up,
    input wire logic [PSSR_NUM_PORTS-1:0] i_jabber,
    input wire logic                      i_core_clk,
    input wire logic                      i_arst_n
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_stat0;
        i_rd && i_addr == 6'h01;
    endsequence
    // Four samples cover the two-stage synchroniser plus the latch
    sequence s_held(v);
        v && $past(v) && $past(v, 2) && $past(v, 3);
    endsequence
    property p_idle; !i_rd |=> o_rdata == 16'h0000; endproperty
    property p_t4; s_stat0 |=> !o_rdata[15]; endproperty
    property p_abil; s_stat0 |=> o_rdata[14:11] == 4'hf; endproperty
    property p_t2; s_stat0 |=> o_rdata[10:9] == 2'h0; endproperty
    property p_an_able; s_stat0 |=> o_rdata[3]; endproperty
    property p_ext; s_stat0 |=> o_rdata[0]; endproperty
    property p_unmapped;
        i_rd && !(i_addr[3:0] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9}) |=> o_rdata == 16'h0000;
    endproperty
    property p_jab; s_held(i_jabber[0]) ##0 s_stat0 |=> o_rdata[1]; endproperty
    property p_rf; s_held(i_rfault[0]) ##0 s_stat0 |=> o_rdata[4]; endproperty
    property p_link; s_held(!i_link_up[0]) ##0 s_stat0 |=> !o_rdata[2]; endproperty
    a_idle: assert property (p_idle) else $error("rdata not zero");
    a_t4: assert property (p_t4) else $error("bit 15 set");
    a_abil: assert property (p_abil) else $error("ability bits");
    a_t2: assert property (p_t2) else $error("bits 10:9 set");
    a_an_able: assert property (p_an_able) else $error("bit 3 low");
    a_ext: assert property (p_ext) else $error("bit 0 low");
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    a_jab: assert property (p_jab) else $error("jabber lost");
    a_rf: assert property (p_rf) else $error("fault lost");
    a_link: assert property (p_link) else $error("link high");
endmodule // pssr_top_chk

bind pssr_top pssr_top_chk u_chk (.i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rfault(i_rfault), .i_link_up(i_link_up), .i_jabber(i_jabber),
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n));

// File: pssr_top_tb.sv
`timescale 1ns/10ps
module pssr_top_tb
    import pssr_pkg::*;
;
    logic        i_core_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, o_irq;
    logic [5:0]  i_addr = 6'h00;
    logic [15:0] i_wdata = 16'h0000, o_rdata, rv;
    logic [1:0]  i_an_done = 2'h0, i_rfault = 2'h0, i_link_up = 2'h0, i_jabber = 2'h0;
    int          errors = 0, checked = 0, cycles = 0;
    pssr_top dut (.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_an_done(i_an_done), .i_rfault(i_rfault),
        .i_link_up(i_link_up), .i_jabber(i_jabber), .o_irq(o_irq),
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n));
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
        cmp(rv, exp);
        // Leave on a clock edge so later pin drives stay edge aligned
        @(posedge i_core_clk);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    task automatic chk_irq(input logic exp);
        #1;
        cmp({15'h0000, o_irq}, {15'h0000, exp});
        @(posedge i_core_clk);
    endtask
    task automatic t_map;
        rdc(6'h01, 16'h7809);
        rdc(6'h11, 16'h7809);
        rdc(6'h04, 16'h0000);
        wr(6'h01, 16'hffff);
        rdc(6'h01, 16'h7809);
        wr(6'h02, 16'hbeef);
        wr(6'h03, 16'hc3a5);
        rdc(6'h02, 16'hbeef);
        rdc(6'h03, 16'hc3a5);
        wr(6'h22, 16'hdead);
        rdc(6'h02, 16'hbeef);
        rdc(6'h21, 16'h0000);
        rdc(6'h12, 16'h1234);
        rdc(6'h13, 16'h56a3);
        $display("test map done");
    endtask
    task automatic t_latch;
        i_jabber <= 2'h1;
        i_rfault <= 2'h1;
        wait_n(5);
        rdc(6'h01, 16'h781b);
        i_jabber <= 2'h0;
        i_rfault <= 2'h0;
        wait_n(4);
        rdc(6'h01, 16'h781b);
        rdc(6'h01, 16'h7809);
        rdc(6'h11, 16'h7809);
        $display("test latch done");
    endtask
    task automatic t_link;
        i_link_up <= 2'h1;
        i_an_done <= 2'h1;
        wait_n(4);
        rdc(6'h01, 16'h7829);
        rdc(6'h01, 16'h782d);
        i_link_up <= 2'h0;
        wait_n(3);
        i_link_up <= 2'h1;
        wait_n(4);
        rdc(6'h01, 16'h7829);
        rdc(6'h01, 16'h782d);
        $display("test link done");
    endtask
    task automatic t_irq;
        wr(6'h09, 16'h0001);
        rdc(6'h08, 16'h000f);
        wait_n(2);
        chk_irq(1'b0);
        i_jabber <= 2'h1;
        wait_n(3);
        i_jabber <= 2'h0;
        wait_n(4);
        chk_irq(1'b1);
        rdc(6'h08, 16'h0001);
        wait_n(2);
        chk_irq(1'b0);
        $display("test irq done");
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        wait_n(12);
        i_arst_n <= 1'b1;
        wait_n(4);
        t_map();
        t_latch();
        t_link();
        t_irq();
        print_verdict();
    end
endmodule // pssr_top_tb
